//--- common/pwg_pkg.sv
package pwg_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int NS_PER_MS = 1000000;

  // Go-sleep unit time and its cycle count
  localparam int SLEEP_UNIT_MS = 20;
  localparam int SLEEP_UNIT_CYC = SLEEP_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int SLEEP_UNIT_W = 24;

  // Shutdown wait period per code, in microseconds
  localparam int WAIT0_US = 1;
  localparam int WAIT1_US = 4;
  localparam int WAIT2_US = 16;
  localparam int WAIT3_US = 64;
  localparam int WAIT0_CYC = WAIT0_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WAIT1_CYC = WAIT1_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WAIT2_CYC = WAIT2_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int WAIT3_CYC = WAIT3_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int IDLE_W = 24;

  // Register offsets on the host bus
  localparam logic [7:0] OFS_MODE_STATUS = 8'h32;
  localparam logic [7:0] OFS_EVENT_ENABLE = 8'h34;
  localparam logic [7:0] OFS_SLEEP_DELAY = 8'h36;
  localparam logic [7:0] OFS_CLOCK_GATING = 8'h38;

  // Field positions
  localparam int STAT_LSB = 2;
  localparam int STAT_MSB = 5;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int POL_BIT = 4;
  localparam int EN_MSB = 3;
  localparam int SW_GATE_BIT = 3;
  localparam int CPU_GATE_BIT = 2;
  localparam int WAIT_MSB = 1;
  localparam int CG_MSB = 4;
  localparam int DELAY_MSB = 7;

  // Reset values
  localparam logic [7:0] SLEEP_DELAY_RST = 8'h8E;
  localparam logic [3:0] STAT_RST = 4'h0;
  localparam logic [4:0] ENABLE_RST = 5'h00;
  localparam logic [4:0] CG_RST = 5'h00;

  // Power management modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_PD = 2'h2;

  // Wake events, ordered as status bits 5 down to 2
  typedef struct packed {
    logic wake_frame;
    logic remote_wake;
    logic link_up;
    logic energy;
  } pwg_event_s;

  // One host bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } pwg_req_s;

endpackage : pwg_pkg

//--- hw/pwg_idle_gate.sv
`timescale 1ns/1ps
// Stops one clock after a stretch of idle cycles, restarts on activity
module pwg_idle_gate (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic gate_en,
  input wire logic busy,
  input wire logic [pwg_pkg::IDLE_W-1:0] limit,
  output logic clk_en
);

  // Consecutive idle cycles, saturating at the limit
  logic [pwg_pkg::IDLE_W-1:0] idle_reg;
  logic [pwg_pkg::IDLE_W-1:0] idle_next;
  // Registered clock enable
  logic run_reg;
  logic run_next;

  // Next idle count and run state
  always_comb begin
    idle_next = idle_reg;
    run_next = 1'b1;
    if (!gate_en || busy) begin
      // Activity or gating off restarts the wait
      idle_next = '0;
    end else if (idle_reg < limit) begin
      idle_next = idle_reg + 1'b1;
    end
    if (gate_en && !busy && idle_reg >= limit) begin
      // Idle longer than the wait period
      run_next = 1'b0;
    end
  end

  // Register idle state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_reg <= '0;
      run_reg <= 1'b1;
    end else begin
      idle_reg <= idle_next;
      run_reg <= run_next;
    end
  end

  assign clk_en = run_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_gate_restart: assert property (busy |=> clk_en) // R12
    else $error("clock not restarted on activity");
  a_gate_always_on: assert property (!gate_en |=> clk_en) // R13
    else $error("clock stopped while gating disabled");
  a_gate_after_wait: assert property ($fell(clk_en) |->
    $past(idle_reg) >= $past(limit) && $past(gate_en)) // R14
    else $error("clock stopped before wait period");

endmodule : pwg_idle_gate

//--- hw/pwg_top.sv
`timescale 1ns/1ps
// Operation
// R1 - Wake-frame status bit 5, cleared by one-write
// R2 - Remote-wake status bit 4, cleared by one-write
// R3 - Link-up status bit 3, cleared by one-write
// R4 - Energy status bit 2, ignored in fiber
// R5 - Mode field: normal, energy, soft power-down
// R6 - Polarity bit 4 sets power-event pin level
// R7 - Enable bit 3 lets wake frame assert
// R8 - Enable bit 2 lets remote wake assert
// R9 - Enable bit 1 lets link-up assert
// R10 - Enable bit 0 lets energy assert
// R11 - Sleep after go-sleep count times 20ms; a count of zero sleeps after one 20ms unit
// R12 - Gate switch clock after media idle
// R13 - Gate CPU clock after host, media idle
// R14 - Wait-period field, reset zero, sets timeout
// R15 - Flags latch always; pin holds until cleared
// R16 - Each wait code maps to cycle constant
module pwg_top #(
  parameter logic [pwg_pkg::SLEEP_UNIT_W-1:0] SLEEP_UNIT_CYC =
    pwg_pkg::SLEEP_UNIT_W'(pwg_pkg::SLEEP_UNIT_CYC),
  parameter logic [pwg_pkg::IDLE_W-1:0] WAIT0_CYC =
    pwg_pkg::IDLE_W'(pwg_pkg::WAIT0_CYC),
  parameter logic [pwg_pkg::IDLE_W-1:0] WAIT1_CYC =
    pwg_pkg::IDLE_W'(pwg_pkg::WAIT1_CYC),
  parameter logic [pwg_pkg::IDLE_W-1:0] WAIT2_CYC =
    pwg_pkg::IDLE_W'(pwg_pkg::WAIT2_CYC),
  parameter logic [pwg_pkg::IDLE_W-1:0] WAIT3_CYC =
    pwg_pkg::IDLE_W'(pwg_pkg::WAIT3_CYC)
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pwg_pkg::pwg_req_s req,
  output logic [15:0] rdata,
  input wire pwg_pkg::pwg_event_s events,
  input wire logic fiber_mode,
  input wire logic media_busy,
  input wire logic host_busy,
  output logic [1:0] power_mode,
  output logic soft_power_down,
  output logic low_power_state,
  output logic power_event_pin,
  output logic switch_clk_en,
  output logic cpu_clk_en
);

  // Write decode per register
  logic wr_status;
  logic wr_enable;
  logic wr_delay;
  logic wr_gating;
  // Event vector with the fiber qualifier applied
  logic [3:0] ev_vec;

  // Register group: host-visible state
  logic [3:0] stat_reg;
  logic [3:0] stat_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic [4:0] enable_reg;
  logic [4:0] enable_next;
  logic [7:0] delay_reg;
  logic [7:0] delay_next;
  logic [4:0] gating_reg;
  logic [4:0] gating_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  // Sleep timer group
  logic [pwg_pkg::SLEEP_UNIT_W-1:0] unit_reg;
  logic [pwg_pkg::SLEEP_UNIT_W-1:0] unit_next;
  logic [7:0] quiet_reg;
  logic [7:0] quiet_next;
  logic sleep_reg;
  logic sleep_next;
  logic unit_tick;

  // Power-event pin group
  logic pin_reg;
  logic pin_next;
  logic any_wake;

  // Idle timeout selected by the wait field
  logic [pwg_pkg::IDLE_W-1:0] wait_limit;
  // Host side counts register traffic as activity
  logic host_act;

  assign wr_status = req.wr && req.addr == pwg_pkg::OFS_MODE_STATUS;
  assign wr_enable = req.wr && req.addr == pwg_pkg::OFS_EVENT_ENABLE;
  assign wr_delay = req.wr && req.addr == pwg_pkg::OFS_SLEEP_DELAY;
  assign wr_gating = req.wr && req.addr == pwg_pkg::OFS_CLOCK_GATING;

  // R4 energy masked in fiber
  assign ev_vec = {events.wake_frame, events.remote_wake, events.link_up,
                   events.energy && !fiber_mode};

  // Next register values and read data
  always_comb begin
    stat_next = stat_reg;
    mode_next = mode_reg;
    enable_next = enable_reg;
    delay_next = delay_reg;
    gating_next = gating_reg;
    rdata_next = rdata_reg;
    // R1 sticky set, W1C
    // R2 sticky set, W1C
    // R3 sticky set, W1C
    // R15 latch regardless of enables
    // A set in the same cycle as a clear wins, so no event is lost
    if (wr_status) begin
      stat_next = stat_reg &
                  ~req.wdata[pwg_pkg::STAT_MSB:pwg_pkg::STAT_LSB];
    end
    stat_next = stat_next | ev_vec;
    // R5 mode field store
    if (wr_status) begin
      mode_next = req.wdata[pwg_pkg::MODE_MSB:pwg_pkg::MODE_LSB];
    end
    if (wr_enable) begin
      enable_next = req.wdata[pwg_pkg::POL_BIT:0];
    end
    if (wr_delay) begin
      delay_next = req.wdata[pwg_pkg::DELAY_MSB:0];
    end
    if (wr_gating) begin
      gating_next = req.wdata[pwg_pkg::CG_MSB:0];
    end
    // Read data, reserved bits and unmapped offsets return zero
    if (req.rd) begin
      case (req.addr)
        pwg_pkg::OFS_MODE_STATUS: begin
          rdata_next = {10'h000, stat_reg, mode_reg};
        end
        pwg_pkg::OFS_EVENT_ENABLE: begin
          rdata_next = {11'h000, enable_reg};
        end
        pwg_pkg::OFS_SLEEP_DELAY: begin
          rdata_next = {8'h00, delay_reg};
        end
        pwg_pkg::OFS_CLOCK_GATING: begin
          rdata_next = {11'h000, gating_reg};
        end
        default: begin
          rdata_next = 16'h0000;
        end
      endcase
    end
  end

  // Register host-visible state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= pwg_pkg::STAT_RST;
      mode_reg <= pwg_pkg::MODE_NORMAL;
      enable_reg <= pwg_pkg::ENABLE_RST;
      delay_reg <= pwg_pkg::SLEEP_DELAY_RST;
      gating_reg <= pwg_pkg::CG_RST;
      rdata_reg <= 16'h0000;
    end else begin
      stat_reg <= stat_next;
      mode_reg <= mode_next;
      enable_reg <= enable_next;
      delay_reg <= delay_next;
      gating_reg <= gating_next;
      rdata_reg <= rdata_next;
    end
  end

  // Sleep timer: the unit divider restarts on energy so quiet is continuous
  assign unit_tick = unit_reg == SLEEP_UNIT_CYC - 1'b1;

  always_comb begin
    unit_next = unit_reg;
    quiet_next = quiet_reg;
    sleep_next = sleep_reg;
    // R11 consecutive quiet time
    if (mode_reg != pwg_pkg::MODE_ENERGY || events.energy) begin
      // Leaving the mode or any energy wakes and restarts the count
      unit_next = '0;
      quiet_next = 8'h00;
      sleep_next = 1'b0;
    end else if (!sleep_reg) begin
      if (unit_tick) begin
        unit_next = '0;
        if (quiet_reg != 8'hFF) begin
          quiet_next = quiet_reg + 8'h01;
        end
        // A count of zero sleeps after the first unit
        if (quiet_reg + 8'h01 >= delay_reg) begin
          sleep_next = 1'b1;
        end
      end else begin
        unit_next = unit_reg + 1'b1;
      end
    end
  end

  // Register sleep timer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unit_reg <= '0;
      quiet_reg <= 8'h00;
      sleep_reg <= 1'b0;
    end else begin
      unit_reg <= unit_next;
      quiet_reg <= quiet_next;
      sleep_reg <= sleep_next;
    end
  end

  // Power-event pin: enabled latched flags, then polarity
  always_comb begin
    // R7 wake frame enable
    // R8 remote wake enable
    // R9 link-up enable
    // R10 energy enable
    any_wake = |(stat_reg & enable_reg[pwg_pkg::EN_MSB:0]);
    // R6 pin polarity select
    pin_next = enable_reg[pwg_pkg::POL_BIT] ? any_wake : !any_wake;
  end

  // Register pin; inactive (low-polarity high) out of reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= pin_next;
    end
  end

  // Wait code to cycle count
  // R14 wait field selects limit
  always_comb begin
    // R16 code to constant
    case (gating_reg[pwg_pkg::WAIT_MSB:0])
      2'h0: wait_limit = WAIT0_CYC;
      2'h1: wait_limit = WAIT1_CYC;
      2'h2: wait_limit = WAIT2_CYC;
      default: wait_limit = WAIT3_CYC;
    endcase
  end

  assign host_act = host_busy || req.wr || req.rd;

  // R12 switch clock gate
  pwg_idle_gate u_switch_gate (
    .clk(clk),
    .reset_n(reset_n),
    .gate_en(gating_reg[pwg_pkg::SW_GATE_BIT]),
    .busy(media_busy),
    .limit(wait_limit),
    .clk_en(switch_clk_en)
  );

  // R13 CPU clock gate
  pwg_idle_gate u_cpu_gate (
    .clk(clk),
    .reset_n(reset_n),
    .gate_en(gating_reg[pwg_pkg::CPU_GATE_BIT]),
    .busy(host_act || media_busy),
    .limit(wait_limit),
    .clk_en(cpu_clk_en)
  );

  assign rdata = rdata_reg;
  assign power_mode = mode_reg;
  assign soft_power_down = mode_reg == pwg_pkg::MODE_SOFT_PD;
  assign low_power_state = sleep_reg;
  assign power_event_pin = pin_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_wake_set: assert property (events.wake_frame |=> stat_reg[3]) // R1
    else $error("wake frame flag not set");
  a_remote_set: assert property (events.remote_wake |=> stat_reg[2]) // R2
    else $error("remote wake flag not set");
  a_link_hold: assert property (stat_reg[1] && !(wr_status &&
    req.wdata[3]) |=> stat_reg[1]) // R3
    else $error("link flag cleared without one-write");
  a_energy_cause: assert property ($rose(stat_reg[0]) |->
    $past(events.energy) && !$past(fiber_mode)) // R4
    else $error("energy flag set without valid energy");
  a_w1c_clear: assert property (wr_status && req.wdata[5] &&
    !events.wake_frame |=> !stat_reg[3]) // R1
    else $error("wake flag not cleared by one-write");
  a_mode_store: assert property (wr_status |=>
    power_mode == $past(req.wdata[1:0])) // R5
    else $error("mode field not stored");
  a_pin_level: assert property (##1 power_event_pin ==
    ($past(enable_reg[4]) ~^ $past(any_wake))) // R6
    else $error("pin level wrong for polarity");
  // An enable or polarity write may legally move the pin, so those are left out
  a_pin_hold: assert property (any_wake && !wr_status && !wr_enable
    |=> ##1 power_event_pin == $past(enable_reg[4])) // R15
    else $error("pin released without clear");
  a_sleep_mode: assert property ($rose(low_power_state) |->
    $past(mode_reg) == pwg_pkg::MODE_ENERGY && $past(unit_tick)) // R11
    else $error("sleep entered outside energy mode");
  a_sleep_wake: assert property (events.energy |=> !low_power_state) // R11
    else $error("energy did not wake");

  c_wake_pin: cover property (events.wake_frame && enable_reg[3]
    ##2 power_event_pin == enable_reg[4]);
  c_sleep: cover property ($rose(low_power_state));
  c_sw_gate: cover property ($fell(switch_clk_en));
  c_cpu_gate: cover property ($fell(cpu_clk_en) ##[1:20] cpu_clk_en);

endmodule : pwg_top

//--- verif/pwg_host_model.sv
`timescale 1ns/1ps
// Host-side bus master: one-cycle strobes, whole 16-bit words
module pwg_host_model (
  input wire logic clk,
  output pwg_pkg::pwg_req_s req,
  input wire logic [15:0] rdata
);
  // Bus idle from time zero, so nothing is taken during reset
  initial req = '0;

  // Write strobe stands for exactly one edge, then the bus goes idle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    d = rdata;
  endtask : rd
endmodule : pwg_host_model

//--- verif/pwg_top_tb_top.sv
`timescale 1ns/1ps
module pwg_top_tb_top;
  logic clk;
  logic reset_n;
  pwg_pkg::pwg_req_s req;
  logic [15:0] rdata;
  pwg_pkg::pwg_event_s events;
  logic fiber_mode;
  logic media_busy;
  logic host_busy;
  logic [1:0] power_mode;
  logic soft_pd;
  logic low_pwr;
  logic pin;
  logic sw_en;
  logic cpu_en;
  int mismatches;
  int n_tests;
  logic [15:0] d;

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Short counts keep the run brief: unit 10, waits 3/5/7/9
  pwg_top #(.SLEEP_UNIT_CYC(24'h00000A), .WAIT0_CYC(24'h000003),
    .WAIT1_CYC(24'h000005), .WAIT2_CYC(24'h000007),
    .WAIT3_CYC(24'h000009)) dut (.clk(clk), .reset_n(reset_n),
    .req(req), .rdata(rdata), .events(events), .fiber_mode(fiber_mode),
    .media_busy(media_busy), .host_busy(host_busy),
    .power_mode(power_mode), .soft_power_down(soft_pd),
    .low_power_state(low_pwr), .power_event_pin(pin),
    .switch_clk_en(sw_en), .cpu_clk_en(cpu_en));

  pwg_host_model host (.clk(clk), .req(req), .rdata(rdata));

  // One compare; four-state match so unknowns never pass
  task automatic chk(input string n, input logic [15:0] s,
    input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [7:0] a,
    input logic [15:0] e);
    host.rd(a, d);
    chk(n, d, e);
  endtask : rchk

  // Waits settle on falling edges, away from the sampling edge
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // One-cycle detector pulse on event i (0 = energy)
  task automatic pulse(input int i);
    @(posedge clk);
    events <= pwg_pkg::pwg_event_s'(4'(1 << i));
    @(posedge clk);
    events <= '0;
  endtask : pulse

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial begin
    reset_n = 1'b0;
    events = '0;
    fiber_mode = 1'b0;
    media_busy = 1'b0;
    host_busy = 1'b0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    cyc(2);
    // Pin idles high out of reset
    chk("pin_rst", 16'(pin), 16'h0001);
    rchk("stat_rst", pwg_pkg::OFS_MODE_STATUS, 16'h0000);
    rchk("en_rst", pwg_pkg::OFS_EVENT_ENABLE, 16'h0000);
    rchk("dly_rst", pwg_pkg::OFS_SLEEP_DELAY, 16'h008E);
    rchk("cg_rst", pwg_pkg::OFS_CLOCK_GATING, 16'h0000);
    host.wr(pwg_pkg::OFS_EVENT_ENABLE, 16'hFFFF);
    rchk("en_rw", pwg_pkg::OFS_EVENT_ENABLE, 16'h001F);
    host.wr(pwg_pkg::OFS_SLEEP_DELAY, 16'hFFFF);
    rchk("dly_rw", pwg_pkg::OFS_SLEEP_DELAY, 16'h00FF);
    host.wr(8'h3A, 16'hFFFF);
    rchk("unmapped", 8'h3A, 16'h0000);
    $display("test registers done");

    // Flags latch while disabled; enable raises pin; one-write clears
    for (int i = 0; i < 4; i++) begin
      host.wr(pwg_pkg::OFS_EVENT_ENABLE, 16'h0010);
      pulse(i);
      cyc(3);
      chk("pin_gated", 16'(pin), 16'h0000);
      rchk("flag_set", pwg_pkg::OFS_MODE_STATUS, 16'(1 << (i + 2)));
      host.wr(pwg_pkg::OFS_EVENT_ENABLE, 16'(16'h0010 | (1 << i)));
      cyc(8);
      chk("pin_on", 16'(pin), 16'h0001);
      host.wr(pwg_pkg::OFS_MODE_STATUS, 16'(1 << (i + 2)));
      cyc(3);
      chk("pin_off", 16'(pin), 16'h0000);
      rchk("flag_clr", pwg_pkg::OFS_MODE_STATUS, 16'h0000);
    end
    // Polarity zero: asserted pin is low
    host.wr(pwg_pkg::OFS_EVENT_ENABLE, 16'h0001);
    pulse(0);
    cyc(3);
    chk("pin_low", 16'(pin), 16'h0000);
    host.wr(pwg_pkg::OFS_MODE_STATUS, 16'h003C);
    host.wr(pwg_pkg::OFS_EVENT_ENABLE, 16'h0000);
    // Fiber masks the energy flag
    @(posedge clk);
    fiber_mode <= 1'b1;
    pulse(0);
    cyc(2);
    rchk("fiber", pwg_pkg::OFS_MODE_STATUS, 16'h0000);
    @(posedge clk);
    fiber_mode <= 1'b0;
    $display("test events done");

    // Every mode code, soft power-down only for 10
    for (int m = 0; m < 4; m++) begin
      host.wr(pwg_pkg::OFS_MODE_STATUS, 16'(m));
      cyc(2);
      chk("mode", 16'(power_mode), 16'(m));
      chk("soft_pd", 16'(soft_pd), 16'(m == 2));
    end
    $display("test modes done");

    // Sleep after two quiet units of 10 cycles; energy wakes
    host.wr(pwg_pkg::OFS_SLEEP_DELAY, 16'h0002);
    host.wr(pwg_pkg::OFS_MODE_STATUS, 16'h0001);
    cyc(12);
    chk("awake", 16'(low_pwr), 16'h0000);
    cyc(20);
    chk("asleep", 16'(low_pwr), 16'h0001);
    pulse(0);
    cyc(3);
    chk("woken", 16'(low_pwr), 16'h0000);
    host.wr(pwg_pkg::OFS_MODE_STATUS, 16'h003C);
    $display("test sleep done");

    // Each wait code gates the switch clock after its own limit
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      media_busy <= 1'b1;
      host.wr(pwg_pkg::OFS_CLOCK_GATING, 16'(16'h0008 | c));
      @(posedge clk);
      media_busy <= 1'b0;
      cyc(3 + 2 * c);
      chk("sw_run", 16'(sw_en), 16'h0001);
      // Close to the fall so a limit one code too long is caught
      cyc(2);
      chk("sw_stop", 16'(sw_en), 16'h0000);
      @(posedge clk);
      media_busy <= 1'b1;
      cyc(2);
      chk("sw_wake", 16'(sw_en), 16'h0001);
    end
    // CPU clock needs host and media idle
    host.wr(pwg_pkg::OFS_CLOCK_GATING, 16'h0004);
    cyc(15);
    chk("cpu_media", 16'(cpu_en), 16'h0001);
    @(posedge clk);
    media_busy <= 1'b0;
    cyc(15);
    chk("cpu_stop", 16'(cpu_en), 16'h0000);
    chk("sw_free", 16'(sw_en), 16'h0001);
    @(posedge clk);
    host_busy <= 1'b1;
    cyc(2);
    chk("cpu_wake", 16'(cpu_en), 16'h0001);
    @(posedge clk);
    host_busy <= 1'b0;
    // Register traffic alone counts as host activity
    cyc(15);
    chk("cpu_idle", 16'(cpu_en), 16'h0000);
    host.wr(pwg_pkg::OFS_CLOCK_GATING, 16'h0004);
    cyc(1);
    chk("cpu_bus", 16'(cpu_en), 16'h0001);
    $display("test gating done");
    end_sim();
  end
endmodule : pwg_top_tb_top
